/* epsp_client_model.sv */
// Network client model: 16-bit holding-register writes and reads
module epsp_client_model (
  input wire logic i_clk,
  input wire logic [15:0] i_reg_rdata,
  output logic o_reg_wr,
  output logic [7:0] o_reg_addr,
  output logic [15:0] o_reg_wdata,
  output logic [7:0] o_reg_raddr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_reg_wr = 1'b0;
    o_reg_addr = 8'h00;
    o_reg_wdata = 16'hA5A5;
    o_reg_raddr = 8'h00;
  end
  task automatic write_word(input logic [7:0] addr, input logic [15:0] data);
    @(negedge i_clk);
    o_reg_wr = 1'b1;
    o_reg_addr = addr;
    o_reg_wdata = data;
  endtask
  // Callers pick range as steps times turns and powers of two
  task automatic write32(input logic [7:0] addr, input logic [31:0] value);
    write_word(addr, value[31:16]);
    write_word(addr + 8'h01, value[15:0]);
    @(negedge i_clk);
    o_reg_wr = 1'b0;
    // Released data must not look like the last word
    o_reg_wdata = ~o_reg_wdata;
  endtask
  task automatic read32(input logic [7:0] addr, output logic [31:0] value);
    @(negedge i_clk);
    o_reg_raddr = addr;
    @(negedge i_clk);
    value[31:16] = i_reg_rdata;
    o_reg_raddr = addr + 8'h01;
    @(negedge i_clk);
    value[15:0] = i_reg_rdata;
  endtask
  // Shaft held still by caller; bit raised then lowered to rearm
  task automatic run_preset();
    write32(epsp_pkg::ADDR_COMMAND, 32'h0000_0800);
    write32(epsp_pkg::ADDR_COMMAND, 32'h0000_0000);
  endtask
endmodule // epsp_client_model

/* epsp_divider.sv */
// Sequential unsigned divider, one quotient bit per clock
module epsp_divider #(
  parameter int WIDTH = 32
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [WIDTH-1:0] i_num,
  input wire logic [WIDTH-1:0] i_den,
  output logic o_busy,
  output logic o_done,
  output logic [WIDTH-1:0] o_quot
);
  epsp_pkg::epsp_div_state_t st_r;
  epsp_pkg::epsp_div_state_t st_nxt;
  logic [WIDTH-1:0] q_r;
  logic [WIDTH-1:0] q_nxt;
  logic [WIDTH:0] rem_r;
  logic [WIDTH:0] rem_nxt;
  logic [WIDTH-1:0] den_r;
  logic [WIDTH-1:0] den_nxt;
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic [WIDTH:0] trial;

  always_comb begin
    st_nxt = st_r;
    q_nxt = q_r;
    rem_nxt = rem_r;
    den_nxt = den_r;
    cnt_nxt = cnt_r;
    trial = {rem_r[WIDTH-1:0], q_r[WIDTH-1]};
    case (st_r)
      epsp_pkg::EPSP_DIV_IDLE: begin
        if (i_start) begin
          q_nxt = i_num;
          den_nxt = i_den;
          rem_nxt = '0;
          cnt_nxt = 6'(WIDTH);
          st_nxt = epsp_pkg::EPSP_DIV_RUN;
        end
      end
      epsp_pkg::EPSP_DIV_RUN: begin
        if (trial >= {1'b0, den_r}) begin
          rem_nxt = trial - {1'b0, den_r};
          q_nxt = {q_r[WIDTH-2:0], 1'b1};
        end else begin
          rem_nxt = trial;
          q_nxt = {q_r[WIDTH-2:0], 1'b0};
        end
        cnt_nxt = cnt_r - 6'h01;
        if (cnt_r == 6'h01) begin
          st_nxt = epsp_pkg::EPSP_DIV_DONE;
        end
      end
      default: begin
        st_nxt = epsp_pkg::EPSP_DIV_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_r <= epsp_pkg::EPSP_DIV_IDLE;
      q_r <= '0;
      rem_r <= '0;
      den_r <= '0;
      cnt_r <= 6'h00;
    end else begin
      st_r <= st_nxt;
      q_r <= q_nxt;
      rem_r <= rem_nxt;
      den_r <= den_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign o_busy = (st_r != epsp_pkg::EPSP_DIV_IDLE);
  assign o_done = (st_r == epsp_pkg::EPSP_DIV_DONE);
  assign o_quot = q_r;
endmodule // epsp_divider

/* epsp_pkg.sv */
// Package: register map, field positions and defaults of the position scaling block
package epsp_pkg;
  // Holding register addresses (16-bit words), first word of each pair is the MSW
  localparam logic [7:0] ADDR_STEPS_PER_TURN = 8'h64;
  localparam logic [7:0] ADDR_OVERALL_STEP_RANGE = 8'h66;
  localparam logic [7:0] ADDR_POSITION_TARGET_VALUE = 8'h68;
  localparam logic [7:0] ADDR_OPER_CFG = 8'h6C;
  localparam logic [7:0] ADDR_COMMAND = 8'h6E;
  localparam logic [7:0] ADDR_HW_STEPS_PER_TURN = 8'h70;
  localparam logic [7:0] ADDR_HW_TURN_COUNT = 8'h72;
  localparam logic [7:0] ADDR_CAPTURED_OFFSET = 8'h7E;
  localparam logic [7:0] ADDR_POSITION_OUT = 8'h5E;
  // Field positions
  localparam int SCALE_EN_BIT = 0;
  localparam int DIR_BIT = 1;
  localparam int PRESET_CMD_BIT = 11;
  // Variant defaults (largest variant)
  localparam logic [31:0] HW_STEPS_PER_TURN_DEF = 32'h0001_0000;
  localparam logic [31:0] HW_TURN_COUNT_DEF = 32'h0000_4000;
  localparam logic [31:0] RANGE_MAX_DEF = 32'h4000_0000;
  localparam logic [31:0] PRESET_MAX_DEF = 32'h3FFF_FFFF;
  localparam logic [31:0] PRESET_RESET = 32'h0000_0000;
  localparam logic [31:0] OFFSET_RESET = 32'h0000_0000;
  localparam logic [1:0] OPER_CFG_RESET = 2'h0;
  // Divider timing
  localparam int DIV_WIDTH = 32;
  typedef enum logic [1:0] {
    EPSP_DIV_IDLE = 2'b00,
    EPSP_DIV_RUN = 2'b01,
    EPSP_DIV_DONE = 2'b11
  } epsp_div_state_t;
endpackage : epsp_pkg

/* epsp_scaling_preset.sv */
// Top: position scaling, range checks and preset offset of an absolute encoder
// Function
// - Custom overall range used only while scaling-enable bit 0 is set.
// - Reject overall range above hardware per-turn times hardware turn count.
// - Overall range accepted from 1 up to the variant maximum.
// - Reject overall range smaller than current custom steps-per-turn.
// - Reject steps-per-turn when range over it needs too many turns.
// - Output equals read position plus preset minus captured offset.
// - Preset is zero until written; captured offset is zero until first preset.
// - Preset command captures current position into the offset register.
// - Command bit 11 set by client applies the stored preset.
// - Preset register resets to zero and accepts up to variant maximum.
// - Preset fires only on a rising edge of its command bit.
// - Each 32-bit value is MSW register then LSW register.
// - Scaled position is physical times custom over hardware per-turn.
module epsp_scaling_preset #(
  parameter logic [31:0] HW_STEPS_PER_TURN = epsp_pkg::HW_STEPS_PER_TURN_DEF,
  parameter logic [31:0] HW_TURN_COUNT = epsp_pkg::HW_TURN_COUNT_DEF,
  parameter logic [31:0] RANGE_MAX = epsp_pkg::RANGE_MAX_DEF,
  parameter logic [31:0] PRESET_MAX = epsp_pkg::PRESET_MAX_DEF
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  input wire logic i_REG_WR,
  input wire logic [7:0] i_REG_ADDR,
  input wire logic [15:0] i_REG_WDATA,
  input wire logic [7:0] i_REG_RADDR,
  input wire logic [31:0] i_PHYS_POS,
  output logic [15:0] o_REG_RDATA,
  output logic o_WR_REJECT,
  output logic [31:0] o_POSITION
);
  // ---------------------------------------------------------------
  // Register pairs
  // ---------------------------------------------------------------
  logic spt_commit;
  logic rng_commit;
  logic pre_commit;
  logic cfg_commit;
  logic cmd_commit;
  logic [31:0] spt_wval;
  logic [31:0] rng_wval;
  logic [31:0] pre_wval;
  logic [31:0] cfg_wval;
  logic [31:0] cmd_wval;

  epsp_word_pair #(.BASE(epsp_pkg::ADDR_STEPS_PER_TURN)) u_spt (
    .i_clk(I_CLK_SYS), .i_rst_n(I_RST_N), .i_wr(i_REG_WR), .i_addr(i_REG_ADDR),
    .i_wdata(i_REG_WDATA), .o_commit(spt_commit), .o_value(spt_wval));
  epsp_word_pair #(.BASE(epsp_pkg::ADDR_OVERALL_STEP_RANGE)) u_rng (
    .i_clk(I_CLK_SYS), .i_rst_n(I_RST_N), .i_wr(i_REG_WR), .i_addr(i_REG_ADDR),
    .i_wdata(i_REG_WDATA), .o_commit(rng_commit), .o_value(rng_wval));
  epsp_word_pair #(.BASE(epsp_pkg::ADDR_POSITION_TARGET_VALUE)) u_pre (
    .i_clk(I_CLK_SYS), .i_rst_n(I_RST_N), .i_wr(i_REG_WR), .i_addr(i_REG_ADDR),
    .i_wdata(i_REG_WDATA), .o_commit(pre_commit), .o_value(pre_wval));
  epsp_word_pair #(.BASE(epsp_pkg::ADDR_OPER_CFG)) u_cfg (
    .i_clk(I_CLK_SYS), .i_rst_n(I_RST_N), .i_wr(i_REG_WR), .i_addr(i_REG_ADDR),
    .i_wdata(i_REG_WDATA), .o_commit(cfg_commit), .o_value(cfg_wval));
  epsp_word_pair #(.BASE(epsp_pkg::ADDR_COMMAND)) u_cmd (
    .i_clk(I_CLK_SYS), .i_rst_n(I_RST_N), .i_wr(i_REG_WR), .i_addr(i_REG_ADDR),
    .i_wdata(i_REG_WDATA), .o_commit(cmd_commit), .o_value(cmd_wval));

  // ---------------------------------------------------------------
  // Stored parameters and checks
  // ---------------------------------------------------------------
  localparam logic [63:0] HW_TOTAL = 64'(HW_STEPS_PER_TURN) * 64'(HW_TURN_COUNT);

  logic [31:0] spt_r, spt_nxt;
  logic [31:0] rng_r, rng_nxt;
  logic [31:0] pre_r, pre_nxt;
  logic [31:0] off_r, off_nxt;
  logic [1:0] cfg_r, cfg_nxt;
  logic cmd_bit_r, cmd_bit_nxt;
  logic rej_r, rej_nxt;
  logic [31:0] pend_spt_r, pend_spt_nxt;
  logic pend_r, pend_nxt;
  logic div_start;
  logic div_busy;
  logic div_done;
  logic [31:0] div_quot;
  logic preset_fire;
  logic [31:0] read_pos;

  epsp_divider #(.WIDTH(epsp_pkg::DIV_WIDTH)) u_div (
    .i_clk(I_CLK_SYS), .i_rst_n(I_RST_N), .i_start(div_start),
    // Divisor is latched at start, so feed the word under test, not the pending copy
    .i_num(rng_r), .i_den(spt_wval), .o_busy(div_busy), .o_done(div_done),
    .o_quot(div_quot));

  assign preset_fire = cmd_commit && cmd_wval[epsp_pkg::PRESET_CMD_BIT] && !cmd_bit_r;

  always_comb begin
    spt_nxt = spt_r;
    rng_nxt = rng_r;
    pre_nxt = pre_r;
    off_nxt = off_r;
    cfg_nxt = cfg_r;
    cmd_bit_nxt = cmd_bit_r;
    rej_nxt = 1'b0;
    pend_spt_nxt = pend_spt_r;
    pend_nxt = pend_r;
    div_start = 1'b0;
    if (rng_commit) begin
      if (rng_wval == 32'h0000_0000 || rng_wval > RANGE_MAX ||
          64'(rng_wval) > HW_TOTAL ||
          rng_wval < spt_r) begin
        rej_nxt = 1'b1;
      end else begin
        rng_nxt = rng_wval;
      end
    end
    // Steps-per-turn waits for the turn-count division before it lands
    if (spt_commit) begin
      if (spt_wval == 32'h0000_0000 || spt_wval > HW_STEPS_PER_TURN || div_busy || pend_r) begin
        rej_nxt = 1'b1;
      end else begin
        pend_spt_nxt = spt_wval;
        pend_nxt = 1'b1;
        div_start = 1'b1;
      end
    end
    if (pend_r && div_done) begin
      pend_nxt = 1'b0;
      if (div_quot > HW_TURN_COUNT) begin
        rej_nxt = 1'b1;
      end else begin
        spt_nxt = pend_spt_r;
      end
    end
    if (pre_commit) begin
      if (pre_wval > PRESET_MAX) begin
        rej_nxt = 1'b1;
      end else begin
        pre_nxt = pre_wval;
      end
    end
    if (cfg_commit) begin
      cfg_nxt = cfg_wval[1:0];
    end
    if (cmd_commit) begin
      cmd_bit_nxt = cmd_wval[epsp_pkg::PRESET_CMD_BIT];
    end
    if (preset_fire) begin
      off_nxt = read_pos;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      spt_r <= HW_STEPS_PER_TURN;
      rng_r <= RANGE_MAX;
      pre_r <= epsp_pkg::PRESET_RESET;
      off_r <= epsp_pkg::OFFSET_RESET;
      cfg_r <= epsp_pkg::OPER_CFG_RESET;
      cmd_bit_r <= 1'b0;
      rej_r <= 1'b0;
      pend_spt_r <= 32'h0000_0001;
      pend_r <= 1'b0;
    end else begin
      spt_r <= spt_nxt;
      rng_r <= rng_nxt;
      pre_r <= pre_nxt;
      off_r <= off_nxt;
      cfg_r <= cfg_nxt;
      cmd_bit_r <= cmd_bit_nxt;
      rej_r <= rej_nxt;
      pend_spt_r <= pend_spt_nxt;
      pend_r <= pend_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Position path
  // ---------------------------------------------------------------
  // Wide product avoids overflow; a power-of-two per-turn count folds the divide
  logic [63:0] scaled_wide;
  logic [31:0] phys_mod;
  logic [31:0] act_range;
  logic [32:0] sum;
  logic [32:0] diff;
  logic [31:0] pos_nxt;
  logic [31:0] pos_r;

  always_comb begin
    phys_mod = 32'(64'(i_PHYS_POS) % HW_TOTAL);
    scaled_wide = (64'(phys_mod) * 64'(spt_r)) / 64'(HW_STEPS_PER_TURN);
    if (cfg_r[epsp_pkg::SCALE_EN_BIT]) begin
      act_range = rng_r;
      read_pos = 32'(scaled_wide % 64'(rng_r));
    end else begin
      act_range = 32'(HW_TOTAL);
      read_pos = phys_mod;
    end
    if (cfg_r[epsp_pkg::DIR_BIT]) begin
      read_pos = (read_pos == 32'h0000_0000) ? 32'h0000_0000 : act_range - read_pos;
    end
    // Modular add and subtract keep every stage below the range
    sum = 33'(read_pos) + 33'(pre_r % act_range);
    if (sum >= 33'(act_range)) begin
      sum = sum - 33'(act_range);
    end
    diff = sum - 33'(off_r % act_range);
    if (diff[32]) begin
      diff = diff + 33'(act_range);
    end
    pos_nxt = diff[31:0];
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      pos_r <= 32'h0000_0000;
    end else begin
      pos_r <= pos_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Read-back
  // ---------------------------------------------------------------
  logic [31:0] rd_word;
  logic [15:0] rd_nxt, rd_r;
  logic [7:0] rd_base;

  always_comb begin
    rd_base = {i_REG_RADDR[7:1], 1'b0};
    rd_word = 32'h0000_0000;
    if (rd_base == epsp_pkg::ADDR_STEPS_PER_TURN) begin
      rd_word = spt_r;
    end else if (rd_base == epsp_pkg::ADDR_OVERALL_STEP_RANGE) begin
      rd_word = rng_r;
    end else if (rd_base == epsp_pkg::ADDR_POSITION_TARGET_VALUE) begin
      rd_word = pre_r;
    end else if (rd_base == epsp_pkg::ADDR_OPER_CFG) begin
      rd_word = {30'h0, cfg_r};
    end else if (rd_base == epsp_pkg::ADDR_COMMAND) begin
      rd_word = {20'h00000, cmd_bit_r, 11'h000};
    end else if (rd_base == epsp_pkg::ADDR_HW_STEPS_PER_TURN) begin
      rd_word = HW_STEPS_PER_TURN;
    end else if (rd_base == epsp_pkg::ADDR_HW_TURN_COUNT) begin
      rd_word = HW_TURN_COUNT;
    end else if (rd_base == epsp_pkg::ADDR_CAPTURED_OFFSET) begin
      rd_word = off_r;
    end else if (rd_base == epsp_pkg::ADDR_POSITION_OUT) begin
      rd_word = pos_r;
    end
    rd_nxt = i_REG_RADDR[0] ? rd_word[15:0] : rd_word[31:16];
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      rd_r <= 16'h0000;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  assign o_REG_RDATA = rd_r;
  assign o_WR_REJECT = rej_r;
  assign o_POSITION = pos_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence cmd_rise_s;
    cmd_commit && cmd_wval[epsp_pkg::PRESET_CMD_BIT] && !cmd_bit_r;
  endsequence

  preset_capture_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    cmd_rise_s |=> off_r == $past(read_pos))
    else $error("offset not captured on preset");
  preset_edge_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    !preset_fire |=> off_r == $past(off_r))
    else $error("offset changed without rising edge");
  range_reject_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (rng_commit && 64'(rng_wval) > HW_TOTAL) |=> rej_r && rng_r == $past(rng_r))
    else $error("oversize range accepted");
  range_min_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (rng_commit && rng_wval < spt_r) |=> rng_r == $past(rng_r))
    else $error("range below steps accepted");
  range_zero_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (rng_commit && rng_wval == 32'h0000_0000) |=> rej_r)
    else $error("zero range accepted");
  preset_max_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    pre_r <= PRESET_MAX)
    else $error("preset above maximum");
  pos_wrap_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    cfg_r[epsp_pkg::SCALE_EN_BIT] |=> pos_r < $past(rng_r))
    else $error("position not below range");
  turn_check_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (pend_r && div_done && div_quot > HW_TURN_COUNT) |=> spt_r == $past(spt_r) && rej_r)
    else $error("steps accepted with too many turns");
  preset_value_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    cmd_rise_s ##1 $stable(read_pos) && $stable(pre_r) |=> pos_r == (pre_r % act_range))
    else $error("position differs from preset after command");
endmodule // epsp_scaling_preset

/* epsp_word_pair.sv */
// One 32-bit parameter built from an MSW/LSW pair of 16-bit holding registers
module epsp_word_pair #(
  parameter logic [7:0] BASE = 8'h00
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wr,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic o_commit,
  output logic [31:0] o_value
);
  logic [15:0] msw_r;
  logic [15:0] msw_nxt;
  logic [31:0] val_nxt;
  logic commit_nxt;
  logic commit_r;
  logic [31:0] val_r;

  // MSW is held until the LSW arrives, then the pair is offered whole
  always_comb begin
    msw_nxt = msw_r;
    val_nxt = val_r;
    commit_nxt = 1'b0;
    if (i_wr && (i_addr == BASE)) begin
      msw_nxt = i_wdata;
    end else if (i_wr && (i_addr == BASE + 8'h01)) begin
      val_nxt = {msw_r, i_wdata};
      commit_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      msw_r <= 16'h0000;
      val_r <= 32'h0000_0000;
      commit_r <= 1'b0;
    end else begin
      msw_r <= msw_nxt;
      val_r <= val_nxt;
      commit_r <= commit_nxt;
    end
  end

  assign o_commit = commit_r;
  assign o_value = val_r;
endmodule // epsp_word_pair

/* test_epsp_scaling_preset.sv */
// Self-checking testbench of the position scaling and preset block
module test_epsp_scaling_preset;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] HWS = epsp_pkg::HW_STEPS_PER_TURN_DEF;
  localparam logic [31:0] RMAX = epsp_pkg::RANGE_MAX_DEF;
  localparam logic [31:0] NEW_RANGE = 32'h0020_0000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] phys_pos = 32'h0000_0000;
  logic wr;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic [7:0] raddr;
  logic [15:0] rdata;
  logic rej;
  logic [31:0] pos;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  // ----------------------------------------
  // Instances
  // ----------------------------------------
  epsp_scaling_preset epsp_scaling_preset_inst (
    .I_CLK_SYS(clk),
    .I_RST_N(rst_n),
    .i_REG_WR(wr),
    .i_REG_ADDR(addr),
    .i_REG_WDATA(wdata),
    .i_REG_RADDR(raddr),
    .i_PHYS_POS(phys_pos),
    .o_REG_RDATA(rdata),
    .o_WR_REJECT(rej),
    .o_POSITION(pos)
  );
  epsp_client_model epsp_client_model_inst (
    .i_clk(clk),
    .i_reg_rdata(rdata),
    .o_reg_wr(wr),
    .o_reg_addr(addr),
    .o_reg_wdata(wdata),
    .o_reg_raddr(raddr)
  );
  always #5 clk = ~clk;
  // Longest run is near 730 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      $display("unexpected at %0t: run did not finish", $time);
      conclude();
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // Steps check runs through a divider, so watch 40 cycles for a refusal
  task automatic wr32(input logic [7:0] a, input logic [31:0] v, input logic exp_rej);
    logic seen;
    seen = 1'b0;
    epsp_client_model_inst.write32(a, v);
    repeat (40) begin
      @(negedge clk);
      if (rej === 1'b1) seen = 1'b1;
    end
    chk({31'h0, seen}, {31'h0, exp_rej}, "write refusal");
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] v;
    epsp_client_model_inst.read32(a, v);
    chk(v, exp, what);
  endtask
  task automatic pos_is(input logic [31:0] exp);
    repeat (4) @(negedge clk);
    chk(pos, exp, "position");
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(epsp_pkg::ADDR_OVERALL_STEP_RANGE, RMAX, "range reset");
    rd(epsp_pkg::ADDR_POSITION_TARGET_VALUE, 32'h0000_0000, "preset reset");
    rd(epsp_pkg::ADDR_CAPTURED_OFFSET, 32'h0000_0000, "offset reset");
    rd(epsp_pkg::ADDR_HW_STEPS_PER_TURN, HWS, "hw steps");
    rd(epsp_pkg::ADDR_HW_TURN_COUNT, epsp_pkg::HW_TURN_COUNT_DEF, "hw turns");
    rd(8'h10, 32'h0000_0000, "unmapped");
    phys_pos = 32'h0000_3039;
    pos_is(32'h0000_3039);
    $display("test reset done");
  endtask
  task automatic t_range();
    wr32(epsp_pkg::ADDR_OVERALL_STEP_RANGE, 32'h0000_0000, 1'b1);
    wr32(epsp_pkg::ADDR_OVERALL_STEP_RANGE, RMAX + 32'h1, 1'b1);
    wr32(epsp_pkg::ADDR_OVERALL_STEP_RANGE, RMAX, 1'b0);
    rd(epsp_pkg::ADDR_OVERALL_STEP_RANGE, RMAX, "range kept");
    $display("test range done");
  endtask
  task automatic t_steps();
    wr32(epsp_pkg::ADDR_STEPS_PER_TURN, 32'h0000_0800, 1'b1);
    rd(epsp_pkg::ADDR_STEPS_PER_TURN, HWS, "steps kept");
    wr32(epsp_pkg::ADDR_OVERALL_STEP_RANGE, NEW_RANGE, 1'b0);
    wr32(epsp_pkg::ADDR_STEPS_PER_TURN, 32'h0000_0800, 1'b0);
    rd(epsp_pkg::ADDR_STEPS_PER_TURN, 32'h0000_0800, "steps");
    wr32(epsp_pkg::ADDR_OVERALL_STEP_RANGE, 32'h0000_03E8, 1'b1);
    rd(epsp_pkg::ADDR_OVERALL_STEP_RANGE, NEW_RANGE, "range kept");
    $display("test steps done");
  endtask
  task automatic t_scale();
    logic [63:0] scaled;
    phys_pos = 32'h0003_8000;
    scaled = ((64'(phys_pos) * 64'h800) / 64'(HWS)) % 64'(NEW_RANGE);
    pos_is(phys_pos);
    wr32(epsp_pkg::ADDR_OPER_CFG, 32'h0000_0001, 1'b0);
    pos_is(scaled[31:0]);
    wr32(epsp_pkg::ADDR_OPER_CFG, 32'h0000_0000, 1'b0);
    pos_is(phys_pos);
    // Reversed count direction without scaling
    wr32(epsp_pkg::ADDR_OPER_CFG, 32'h0000_0002, 1'b0);
    rd(epsp_pkg::ADDR_OPER_CFG, 32'h0000_0002, "config");
    pos_is(RMAX - phys_pos);
    wr32(epsp_pkg::ADDR_OPER_CFG, 32'h0000_0000, 1'b0);
    $display("test scaling done");
  endtask
  task automatic t_preset();
    wr32(epsp_pkg::ADDR_POSITION_TARGET_VALUE, epsp_pkg::PRESET_MAX_DEF + 32'h1, 1'b1);
    rd(epsp_pkg::ADDR_POSITION_TARGET_VALUE, 32'h0000_0000, "preset kept");
    wr32(epsp_pkg::ADDR_POSITION_TARGET_VALUE, 32'h0000_0032, 1'b0);
    phys_pos = 32'h0000_03E8;
    epsp_client_model_inst.run_preset();
    pos_is(32'h0000_0032);
    rd(epsp_pkg::ADDR_CAPTURED_OFFSET, 32'h0000_03E8, "offset");
    phys_pos = 32'h0000_03E9;
    pos_is(32'h0000_0033);
    rd(epsp_pkg::ADDR_POSITION_OUT, 32'h0000_0033, "position word");
    phys_pos = 32'h0000_0000;
    pos_is(RMAX - 32'h0000_03B6);
    phys_pos = 32'h0000_07D0;
    epsp_client_model_inst.write32(epsp_pkg::ADDR_COMMAND, 32'h0000_0800);
    pos_is(32'h0000_0032);
    phys_pos = 32'h0000_07DA;
    epsp_client_model_inst.write32(epsp_pkg::ADDR_COMMAND, 32'h0000_0800);
    pos_is(32'h0000_003C);
    rd(epsp_pkg::ADDR_COMMAND, 32'h0000_0800, "command bit");
    // Bit still high, so lower it before the next rising edge
    epsp_client_model_inst.write32(epsp_pkg::ADDR_COMMAND, 32'h0000_0000);
    epsp_client_model_inst.run_preset();
    pos_is(32'h0000_0032);
    // Scaling enabled: client re-runs the preset, kept below the custom range
    wr32(epsp_pkg::ADDR_OPER_CFG, 32'h0000_0001, 1'b0);
    epsp_client_model_inst.run_preset();
    pos_is(32'h0000_0032);
    rd(epsp_pkg::ADDR_CAPTURED_OFFSET, 32'h0000_003E, "scaled offset");
    $display("test preset done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_range();
    t_steps();
    t_scale();
    t_preset();
    conclude();
  end
endmodule // test_epsp_scaling_preset
